// ==== core/baud_clock_defs.vh ====
// Purpose: constants for the serial transfer-clock generator
// Assumes: AHB-Lite register access, 32-bit word per register
// Notes: offsets are byte addresses
`ifndef BAUD_CLOCK_DEFS_VH
`define BAUD_CLOCK_DEFS_VH
`define ADDR_DIVIDER_CONTROL 4'h0
`define ADDR_FRACTION_ADJUST 4'h4
`define ADDR_CHANNEL_MODE 4'h8
`define ADDR_CHANNEL_CONTROL 4'hc
`define ADDR_STATUS 5'h10
`define ADDR_UNMAPPED 5'h1f
// divider control fields
`define DIV_N_LSB 0
`define DIV_N_MSB 3
`define DIV_TAP_LSB 4
`define DIV_TAP_MSB 5
`define DIV_FRAC_EN 6
// fraction adjust
`define FRAC_K_LSB 0
`define FRAC_K_MSB 3
// channel mode fields
`define MODE_LSB 0
`define MODE_MSB 1
`define MODE_SRC_LSB 2
`define MODE_SRC_MSB 3
`define MODE_PARITY_EN 4
`define MODE_WAKEUP 5
// channel control fields
`define CTRL_SCLK_IN 0
// mode codes
`define MODE_SHIFT 2'b00
`define MODE_ASYNC7 2'b01
`define MODE_ASYNC8 2'b10
`define MODE_ASYNC9 2'b11
// basic clock sources
`define SRC_BRG 2'b00
`define SRC_HALF 2'b01
`define SRC_TIMER 2'b10
`define SRC_EXT 2'b11
// taps
`define TAP_DIV4 2'b00
`define TAP_DIV16 2'b01
`define TAP_DIV64 2'b10
`define TAP_DIV256 2'b11
`define PRESCALE_WIDTH 6
`define DIVISOR_WIDTH 4
`define HTRANS_NONSEQ 2'b10
`define RESET_BYTE 8'h00
`endif

// ==== core/fraction_divider.v ====
// Purpose: baud generator, divides tap pulses by N or N+(16-K)/16
// Assumes: tick is a one-cycle pulse per prescaler tap period
// Notes: fraction spread by a 4-bit accumulator
`timescale 1ns/1ps
`default_nettype none
`include "baud_clock_defs.vh"
module fraction_divider #(
  parameter WIDTH = `DIVISOR_WIDTH
) (
  input wire hclk,
  input wire hresetn,
  input wire tick,
  input wire [WIDTH-1:0] n_code,
  input wire [WIDTH-1:0] k_code,
  input wire frac_on,
  output reg pulse
);
  reg [WIDTH:0] count;
  reg [WIDTH-1:0] acc;
  reg stretch;
  wire [WIDTH:0] n_value;
  wire [WIDTH:0] target;
  wire [WIDTH:0] acc_sum;
  // code zero means sixteen
  assign n_value = (n_code == {WIDTH{1'b0}}) ? {1'b1, {WIDTH{1'b0}}} : {1'b0, n_code};
  // one extra input cycle when stretching this period
  assign target = stretch ? n_value : n_value - {{WIDTH{1'b0}}, 1'b1};
  // accumulate 16-K per output; carry marks a long period
  assign acc_sum = {1'b0, acc} + ({1'b1, {WIDTH{1'b0}}} - {1'b0, k_code});
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= {(WIDTH+1){1'b0}};
      acc <= {WIDTH{1'b0}};
      stretch <= 1'b0;
      pulse <= 1'b0;
    end else begin
      pulse <= 1'b0;
      if (tick) begin
        if (count >= target) begin
          count <= {(WIDTH+1){1'b0}};
          pulse <= 1'b1;
          // k zero disables the fraction; frac off ignores k
          if (frac_on && k_code != {WIDTH{1'b0}}) begin
            acc <= acc_sum[WIDTH-1:0];
            stretch <= acc_sum[WIDTH];
          end else begin
            acc <= {WIDTH{1'b0}};
            stretch <= 1'b0;
          end
        end else begin
          count <= count + {{WIDTH{1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // fraction_divider
`default_nettype wire

// ==== core/edge_pulse.v ====
// Purpose: rising-edge pulse from a synchronous level
// Assumes: input already synchronous to hclk
// Notes: one per external clock source
`timescale 1ns/1ps
`default_nettype none
module edge_pulse #(
  parameter IDLE_LEVEL = 1'b0
) (
  input wire hclk,
  input wire hresetn,
  input wire level,
  output wire pulse
);
  reg last;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // start at the pin's idle level, else reset fakes an edge
      last <= IDLE_LEVEL;
    end else begin
      last <= level;
    end
  end
  assign pulse = level & ~last;
endmodule // edge_pulse
`default_nettype wire

// ==== core/serial_baud_clock_generator.v ====
// Purpose: transfer-clock generation for one serial channel, AHB-Lite registers
// Assumes: pins synchronous to hclk; instantiate once per channel
// Notes: produces basic clock pulse, bit-rate pulse and shift clock pin
// How it works
// - channel is either asynchronous framed or synchronous shift
// - mode 0 shift, modes 1..3 carry 7, 8, 9 data bits
// - parity option exposed only in 7-bit and 8-bit modes
// - 9-bit mode exposes the wake-up enable
// - channels are identical copies of this block with own pins
// - 6-bit prescaler runs whenever the generator is the source
// - taps have periods of 4, 16, 64 and 256 clocks
// - 2-bit tap select in divider control picks the generator input
// - generator divides by N, or N+(16-K)/16
// - fraction enable picks plain or fractional division for N codes 2..15; N codes 0 and 1 always divide plain
// - N code zero means 16; codes 1..15 mean themselves
// - K code zero disables fraction, 1..15 are K
// - fraction enable low ignores K entirely
// - shift mode has no fraction; hardware forces it off
// - bit rate is generator output over 16 async, over 2 sync
// - external clock over 16 async, direct in sync mode
// - timer match never clocks the shift mode
// - shift mode with driven clock halves the generator output
// - async source field picks generator, fc/2, timer, or pin
`timescale 1ns/1ps
`default_nettype none
`include "baud_clock_defs.vh"
module serial_baud_clock_generator #(
  parameter PRESCALE_WIDTH = `PRESCALE_WIDTH,
  parameter DIVISOR_WIDTH = `DIVISOR_WIDTH
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire timer_match,
  input wire shift_clock_pin_in,
  output reg shift_clock_pin_out,
  output wire shift_clock_pin_oe,
  output reg basic_serial_clock,
  output reg bit_rate_pulse,
  output wire [1:0] channel_mode,
  output wire parity_enable,
  output wire wakeup_enable
);
  // registers
  reg [7:0] baud_divider_control;
  reg [7:0] baud_fraction_adjust;
  reg [7:0] channel_mode_register;
  reg [7:0] channel_control_register;
  // bus state
  reg wr_pending;
  reg [4:0] wr_addr;
  // clock path
  reg [PRESCALE_WIDTH-1:0] prescaler;
  reg [PRESCALE_WIDTH-1:0] next_prescaler;
  reg tap_tick;
  reg [3:0] bit_count;
  reg half_toggle;
  reg next_basic;
  wire [1:0] mode;
  wire [1:0] source;
  wire [1:0] tap_sel;
  wire sclk_input;
  wire is_shift;
  wire brg_selected;
  wire frac_allowed;
  wire brg_pulse;
  wire ext_pulse;
  wire timer_pulse;
  wire bus_take;
  wire [4:0] bus_index;
  reg [1:0] wrap_count;
  wire half_wrap_done;
  assign mode = channel_mode_register[`MODE_MSB:`MODE_LSB];
  assign source = channel_mode_register[`MODE_SRC_MSB:`MODE_SRC_LSB];
  assign tap_sel = baud_divider_control[`DIV_TAP_MSB:`DIV_TAP_LSB];
  assign sclk_input = channel_control_register[`CTRL_SCLK_IN];
  assign is_shift = (mode == `MODE_SHIFT);
  assign channel_mode = mode;
  // parity only meaningful in 7 and 8 bit frames
  assign parity_enable = channel_mode_register[`MODE_PARITY_EN] &&
    (mode == `MODE_ASYNC7 || mode == `MODE_ASYNC8);
  assign wakeup_enable = channel_mode_register[`MODE_WAKEUP] && (mode == `MODE_ASYNC9);
  // the pin is driven only when shift mode outputs its own clock
  assign shift_clock_pin_oe = is_shift && !sclk_input;
  // AHB-Lite slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign bus_take = hsel && hready && (htrans == `HTRANS_NONSEQ);
  // upper address bits must be zero, so aliases of the map stay unmapped
  assign bus_index = (haddr[31:5] == 27'h000_0000) ? haddr[4:0] : `ADDR_UNMAPPED;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      wr_addr <= 5'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pending <= bus_take && hwrite;
      if (bus_take) begin
        wr_addr <= bus_index;
      end
      if (bus_take && !hwrite) begin
        case (bus_index)
          {1'b0, `ADDR_DIVIDER_CONTROL}: hrdata <= {24'h00_0000, baud_divider_control};
          {1'b0, `ADDR_FRACTION_ADJUST}: hrdata <= {24'h00_0000, baud_fraction_adjust};
          {1'b0, `ADDR_CHANNEL_MODE}: hrdata <= {24'h00_0000, channel_mode_register};
          {1'b0, `ADDR_CHANNEL_CONTROL}: hrdata <= {24'h00_0000, channel_control_register};
          // live view of the clock path
          `ADDR_STATUS: hrdata <= {24'h00_0000, shift_clock_pin_out, basic_serial_clock, brg_selected,
            frac_allowed, bit_count};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      baud_divider_control <= `RESET_BYTE;
      baud_fraction_adjust <= `RESET_BYTE;
      channel_mode_register <= `RESET_BYTE;
      channel_control_register <= `RESET_BYTE;
    end else if (wr_pending) begin
      case (wr_addr)
        {1'b0, `ADDR_DIVIDER_CONTROL}: baud_divider_control <= {1'b0, hwdata[6:0]};
        {1'b0, `ADDR_FRACTION_ADJUST}: baud_fraction_adjust <= {4'h0, hwdata[3:0]};
        {1'b0, `ADDR_CHANNEL_MODE}: channel_mode_register <= {2'b00, hwdata[5:0]};
        {1'b0, `ADDR_CHANNEL_CONTROL}: channel_control_register <= {7'h00, hwdata[0]};
        default: baud_divider_control <= baud_divider_control;
      endcase
    end
  end
  // generator used when shift mode drives its clock or async picks it
  assign brg_selected = is_shift ? !sclk_input : (source == `SRC_BRG);
  // software should clear it for N 1/16 and in shift mode; hardware also masks it
  assign frac_allowed = baud_divider_control[`DIV_FRAC_EN] && !is_shift &&
    (baud_divider_control[`DIV_N_MSB:`DIV_N_LSB] != 4'h0) &&
    (baud_divider_control[`DIV_N_MSB:`DIV_N_LSB] != 4'h1);
  // prescaler stops while idle to save power
  always @* begin
    next_prescaler = prescaler;
    if (brg_selected) begin
      next_prescaler = prescaler + {{(PRESCALE_WIDTH-1){1'b0}}, 1'b1};
    end
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prescaler <= {PRESCALE_WIDTH{1'b0}};
      tap_tick <= 1'b0;
    end else begin
      prescaler <= next_prescaler;
      case (tap_sel)
        `TAP_DIV4: tap_tick <= brg_selected && (prescaler[1:0] == 2'b11);
        `TAP_DIV16: tap_tick <= brg_selected && (prescaler[3:0] == 4'hf);
        `TAP_DIV64: tap_tick <= brg_selected && (prescaler[5:0] == 6'h3f);
        // 256 extends past the 6-bit prescaler by four wraps
        `TAP_DIV256: tap_tick <= brg_selected && (prescaler[5:0] == 6'h3f) && half_wrap_done;
        default: tap_tick <= 1'b0;
      endcase
    end
  end
  assign half_wrap_done = (wrap_count == 2'b11);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wrap_count <= 2'b00;
    end else if (brg_selected && prescaler[5:0] == 6'h3f) begin
      wrap_count <= wrap_count + 2'b01;
    end
  end
  fraction_divider #(
    .WIDTH(DIVISOR_WIDTH)
  ) u_divider (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tap_tick),
    .n_code(baud_divider_control[`DIV_N_MSB:`DIV_N_LSB]),
    .k_code(baud_fraction_adjust[`FRAC_K_MSB:`FRAC_K_LSB]),
    .frac_on(frac_allowed),
    .pulse(brg_pulse)
  );
  // pin idles high through its pull-up
  edge_pulse #(
    .IDLE_LEVEL(1'b1)
  ) u_ext_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .level(shift_clock_pin_in),
    .pulse(ext_pulse)
  );
  edge_pulse u_timer_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .level(timer_match),
    .pulse(timer_pulse)
  );
  // basic clock selection
  always @* begin
    next_basic = 1'b0;
    if (is_shift) begin
      // timer match is never a shift-mode source
      next_basic = sclk_input ? ext_pulse : (brg_pulse && half_toggle);
    end else begin
      case (source)
        `SRC_BRG: next_basic = brg_pulse;
        `SRC_HALF: next_basic = half_toggle;
        `SRC_TIMER: next_basic = timer_pulse;
        `SRC_EXT: next_basic = ext_pulse;
        default: next_basic = 1'b0;
      endcase
    end
    // a source switch could otherwise land two pulses back to back
    if (basic_serial_clock) begin
      next_basic = 1'b0;
    end
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      half_toggle <= 1'b0;
      basic_serial_clock <= 1'b0;
      bit_rate_pulse <= 1'b0;
      bit_count <= 4'h0;
      shift_clock_pin_out <= 1'b1;
    end else begin
      if (is_shift ? brg_pulse : 1'b1) begin
        half_toggle <= ~half_toggle;
      end
      basic_serial_clock <= next_basic;
      bit_rate_pulse <= 1'b0;
      if (is_shift) begin
        bit_count <= 4'h0;
        bit_rate_pulse <= next_basic;
        if (!sclk_input && brg_pulse) begin
          shift_clock_pin_out <= ~half_toggle;
        end
      end else begin
        shift_clock_pin_out <= 1'b1;
        if (next_basic) begin
          bit_count <= bit_count + 4'h1;
          bit_rate_pulse <= (bit_count == 4'hf);
        end
      end
    end
  end
endmodule // serial_baud_clock_generator
`default_nettype wire

// ==== verification/serial_baud_clock_generator_props.sv ====
// Purpose: port checks for the transfer-clock generator
// Assumes: one clock, async active-low reset
// Notes: bound to every generator instance
`timescale 1ns/1ps
`default_nettype none
module serial_baud_clock_generator_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic shift_clock_pin_in,
  input wire logic shift_clock_pin_oe,
  input wire logic basic_serial_clock,
  input wire logic bit_rate_pulse,
  input wire logic [1:0] channel_mode,
  input wire logic parity_enable,
  input wire logic wakeup_enable
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic pin_q;
  logic [2:0] rise_hist;
  // pin edge history, lets an input-mode clock be traced to its cause
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_q <= 1'b1;
      rise_hist <= 3'h0;
    end else begin
      pin_q <= shift_clock_pin_in;
      rise_hist <= {rise_hist[1:0], shift_clock_pin_in & ~pin_q};
    end
  end
  sequence s_bit_quiet; !bit_rate_pulse [*7]; endsequence
  sequence s_basic_quiet; !basic_serial_clock [*7]; endsequence
  property p_bus_okay; hreadyout && !hresp; endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus answer not ready or not okay");
  property p_parity; parity_enable |-> channel_mode inside {2'h1, 2'h2}; endproperty
  a_parity: assert property (p_parity) else $error("parity outside 7/8-bit mode");
  property p_wake; wakeup_enable |-> channel_mode == 2'h3; endproperty
  a_wake: assert property (p_wake) else $error("wake-up outside 9-bit mode");
  property p_oe; shift_clock_pin_oe |-> channel_mode == 2'h0; endproperty
  a_oe: assert property (p_oe) else $error("shift clock driven outside shift mode");
  property p_basic_single; basic_serial_clock |=> !basic_serial_clock; endproperty
  a_basic_single: assert property (p_basic_single) else $error("basic clock too fast");
  property p_bit_gap; bit_rate_pulse |=> s_bit_quiet; endproperty
  a_bit_gap: assert property (p_bit_gap) else $error("bit pulses too close");
  property p_shift_out_gap; shift_clock_pin_oe && basic_serial_clock |=> s_basic_quiet; endproperty
  a_shift_out_gap: assert property (p_shift_out_gap) else $error("shift clock not halved");
  property p_shift_in_src;
    basic_serial_clock && channel_mode == 2'h0 && !shift_clock_pin_oe && !$past(shift_clock_pin_oe)
      |-> |rise_hist;
  endproperty
  a_shift_in_src: assert property (p_shift_in_src) else $error("input shift clock w/o pin edge");
endmodule // serial_baud_clock_generator_props
bind serial_baud_clock_generator serial_baud_clock_generator_props serial_baud_clock_generator_props_i (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .shift_clock_pin_in(shift_clock_pin_in), .shift_clock_pin_oe(shift_clock_pin_oe),
  .basic_serial_clock(basic_serial_clock), .bit_rate_pulse(bit_rate_pulse),
  .channel_mode(channel_mode), .parity_enable(parity_enable), .wakeup_enable(wakeup_enable));
`default_nettype wire

// ==== verification/shift_clock_peer.sv ====
// Purpose: far-side peer that drives the shift clock pin
// Assumes: pin pulled high when nobody drives it
// Notes: clock stands high outside frames
`timescale 1ns/1ps
`default_nettype none
module shift_clock_peer (
  input wire logic hclk,
  input wire logic run,
  input wire logic [4:0] half,
  output logic drive
);
  logic [4:0] cnt;
  initial begin
    drive = 1'b1;
    cnt = 5'h0;
  end
  // half period in system clocks; callers keep it slow enough for shift mode
  always @(posedge hclk) begin
    if (!run) begin
      drive <= 1'b1;
      cnt <= 5'h0;
    end else if (cnt == half - 5'h1) begin
      drive <= ~drive;
      cnt <= 5'h0;
    end else begin
      cnt <= cnt + 5'h1;
    end
  end
endmodule // shift_clock_peer
`default_nettype wire

// ==== verification/serial_baud_clock_generator_tb_top.sv ====
// Purpose: self-checking bench for the transfer-clock generator
// Assumes: zero-wait AHB-Lite slave, 8 ns clock
// Notes: rates are checked as pulse spacing in clocks
`timescale 1ns/1ps
`default_nettype none
module serial_baud_clock_generator_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic timer_match = 1'b0;
  logic run = 1'b0;
  logic [4:0] half = 5'h8;
  logic [3:0] tcnt = 4'h0;
  logic [31:0] hrdata, rdat;
  logic hreadyout, hresp, pin_out, pin_oe, basic, bitp, par, wake, peer_drive, pin_wire;
  logic [1:0] mode;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  always #4 hclk = ~hclk;
  // pull-up wire: peer drives only while the device does not
  assign pin_wire = pin_oe ? pin_out : peer_drive;
  serial_baud_clock_generator serial_baud_clock_generator_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer_match(timer_match), .shift_clock_pin_in(pin_wire), .shift_clock_pin_out(pin_out),
    .shift_clock_pin_oe(pin_oe), .basic_serial_clock(basic), .bit_rate_pulse(bitp),
    .channel_mode(mode), .parity_enable(par), .wakeup_enable(wake));
  shift_clock_peer shift_clock_peer_i (.hclk(hclk), .run(run), .half(half), .drive(peer_drive));
  // timer ticks every 10 clocks, left running so shift mode must ignore it
  always @(posedge hclk) begin
    tcnt <= (tcnt == 4'h9) ? 4'h0 : tcnt + 4'h1;
    timer_match <= (tcnt < 4'h5);
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic finish_test;
    if (bad_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rdat, exp);
  endtask
  // measure from the second pulse to the third: the interval after a setting change may be partial
  task automatic gap(input logic b, input int exp);
    int n;
    n = 0;
    repeat (2) begin
      @(posedge hclk);
      while ((b ? bitp : basic) !== 1'b1) @(posedge hclk);
    end
    do begin
      @(posedge hclk);
      n++;
    end while ((b ? bitp : basic) !== 1'b1);
    chk(n, exp);
  endtask
  task automatic t_reset;
    for (int i = 0; i < 4; i++) rc(8'(i * 4), 32'h0000_0000);
    rc(8'h10, 32'h0000_00A0);
    chk({31'h0, pin_oe}, 32'h0000_0001);
    chk({31'h0, pin_out}, 32'h0000_0001);
  endtask
  task automatic t_regs;
    bus(1'b1, 8'h00, 32'hFFFF_FF7F);
    rc(8'h00, 32'h0000_007F);
    bus(1'b1, 8'h04, 32'h0000_000F);
    rc(8'h04, 32'h0000_000F);
    bus(1'b1, 8'h20, 32'hFFFF_FFFF);
    rc(8'h20, 32'h0000_0000);
    rc(8'h00, 32'h0000_007F);
  endtask
  task automatic t_taps;
    bus(1'b1, 8'h08, 32'h0000_0001);
    for (int t = 0; t < 4; t++) begin
      bus(1'b1, 8'h00, {26'h0, t[1:0], 4'h3});
      gap(1'b0, 3 * (4 << (2 * t)));
    end
    bus(1'b1, 8'h00, 32'h0000_0000);
    gap(1'b0, 64);
    bus(1'b1, 8'h00, 32'h0000_0001);
    gap(1'b0, 4);
    gap(1'b1, 64);
  endtask
  task automatic t_frac;
    bus(1'b1, 8'h04, 32'h0000_0008);
    bus(1'b1, 8'h00, 32'h0000_0046);
    gap(1'b1, 416);
    bus(1'b1, 8'h00, 32'h0000_0006);
    gap(1'b1, 384);
    bus(1'b1, 8'h04, 32'h0000_0000);
    bus(1'b1, 8'h00, 32'h0000_0046);
    gap(1'b1, 384);
  endtask
  task automatic t_shift_out;
    bus(1'b1, 8'h04, 32'h0000_0005);
    bus(1'b1, 8'h00, 32'h0000_0042);
    bus(1'b1, 8'h08, 32'h0000_0000);
    bus(1'b1, 8'h0C, 32'h0000_0000);
    gap(1'b0, 16);
    gap(1'b1, 16);
  endtask
  task automatic t_sources;
    bus(1'b1, 8'h08, 32'h0000_0006);
    gap(1'b0, 2);
    gap(1'b1, 32);
    bus(1'b1, 8'h08, 32'h0000_000B);
    gap(1'b0, 10);
    bus(1'b1, 8'h08, 32'h0000_000D);
    half <= 5'h4;
    run <= 1'b1;
    gap(1'b0, 8);
    gap(1'b1, 128);
    run <= 1'b0;
  endtask
  task automatic t_shift_in;
    bus(1'b1, 8'h0C, 32'h0000_0001);
    bus(1'b1, 8'h08, 32'h0000_0000);
    half <= 5'h8;
    run <= 1'b1;
    gap(1'b0, 16);
    chk({31'h0, pin_oe}, 32'h0000_0000);
    run <= 1'b0;
  endtask
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, 8'h08, 32'h0000_0030 | m);
      // the write lands at the edge that ends the data phase
      @(posedge hclk);
      chk({30'h0, mode}, m);
      chk({31'h0, par}, {31'h0, m == 1 || m == 2});
      chk({31'h0, wake}, {31'h0, m == 3});
    end
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_regs();
    t_taps();
    t_frac();
    t_shift_out();
    t_sources();
    t_shift_in();
    t_modes();
    finish_test();
  end
endmodule // serial_baud_clock_generator_tb_top
`default_nettype wire
